// [include/dio_defs.svh]
// register offsets, field positions and reset values of the dual i/o port
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH

// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define DIO_IDX_PORT_A_PINS 8'h05
`define DIO_IDX_PORT_B_PINS 8'h06
`define DIO_IDX_FLAGS 8'h0B
`define DIO_IDX_RMW_MASK 8'h1E
`define DIO_IDX_CMP_CTRL 8'h1F
`define DIO_IDX_OPTIONS 8'h81
`define DIO_IDX_PORT_A_DIR 8'h85
`define DIO_IDX_PORT_B_DIR 8'h86
`define DIO_IDX_REF_CTRL 8'h9F

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DIO_RST_OPTIONS 8'hFF
`define DIO_RST_PORT_B_DIR 8'hFF
`define DIO_RST_PORT_A_DIR 5'h1F
`define DIO_RST_CMP_CTRL 8'h00
`define DIO_RST_REF_CTRL 8'h00
`define DIO_RST_RMW_MASK 8'hFF
`define DIO_RST_FLAGS 8'h00

// ----------------------------------------------------------------
// field positions and encodings
// ----------------------------------------------------------------
`define DIO_OPT_PULLUP_DIS_N 7
`define DIO_OPT_EDGE_RISE 6
`define DIO_FLG_CHANGE 0
`define DIO_FLG_EXT 1
`define DIO_FLG_EXT_EN 4
`define DIO_REF_EN 7
`define DIO_REF_OE 6
`define DIO_CM_RESET 3'h0
`define DIO_CM_OUTPUTS 3'h6
`define DIO_CM_OFF 3'h7
`define DIO_AN_MASK_ALL 4'hF
`define DIO_AN_MASK_OUT 4'h7

`endif

// [include/dio_pkg.sv]
// types shared by the dual i/o port files
package dio_pkg;
	typedef enum logic [0:0] {
		DIO_BUS_IDLE = 1'b0,
		DIO_BUS_ACK = 1'b1
	} dio_bus_e;
	typedef logic [7:0] dio_byte_t;
endpackage

// [logic/dio_chg_det.sv]
// level change detector for the upper port b pins
`timescale 1ns/1ps
module dio_chg_det
	import dio_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// pins
	input wire logic [3:0] pins,
	input wire logic [3:0] in_mask,
	// result
	output logic change
);
	logic [3:0] prev_ff;
	logic armed_ff;
	logic [3:0] diff;

	// armed after the first sample so the reset value of prev_ff never reads as a change
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_ff <= 4'h0;
			armed_ff <= 1'b0;
		end else begin
			prev_ff <= pins;
			armed_ff <= 1'b1;
		end
	end

	// only pins set as inputs take part
	generate
		for (genvar i = 0; i < 4; i++) begin : g_bit
			assign diff[i] = armed_ff & in_mask[i] & (pins[i] ^ prev_ff[i]);
		end
	endgenerate

	assign change = |diff;
endmodule

// [logic/dio_top.sv]
// dual i/o port with pin sharing, avalon-mm register slave
`timescale 1ns/1ps
`include "dio_defs.svh"
module dio_top
	import dio_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// avalon-mm slave
	input wire logic [9:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [3:0] avs_byteenable,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// port a pins
	input wire logic [4:0] pa_in,
	output logic [4:0] pa_out,
	output logic [4:0] pa_oe,
	// port b pins
	input wire logic [7:0] pb_in,
	output logic [7:0] pb_out,
	output logic [7:0] pb_oe,
	output logic [7:0] pb_pullup_en,
	output logic [7:0] pb_schmitt_en,
	// shared functions
	input wire logic [1:0] cmp_result,
	input wire logic prog_mode,
	output logic timer_ext_clock_in,
	output logic [2:0] cmp_mode,
	output logic cmp_force_gnd,
	output logic vref_out_en,
	output logic port_change_flag,
	output logic ext_int_flag
);
	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	dio_bus_e bus_ff;
	logic waitreq_ff;
	logic [31:0] rdata_ff;
	logic [4:0] pa_latch_ff;
	logic [4:0] pa_dir_ff;
	dio_byte_t pb_latch_ff;
	dio_byte_t pb_dir_ff;
	dio_byte_t opt_ff;
	dio_byte_t cmp_ctrl_ff;
	dio_byte_t ref_ctrl_ff;
	dio_byte_t rmw_mask_ff;
	logic chg_flag_ff;
	logic ext_flag_ff;
	logic ext_en_ff;
	logic pb0_prev_ff;
	logic pb0_arm_ff;
	logic [4:0] pa_out_ff;
	logic [4:0] pa_oe_ff;
	dio_byte_t pb_out_ff;
	dio_byte_t pb_oe_ff;
	dio_byte_t pb_pu_ff;
	dio_byte_t pb_st_ff;
	logic tmr_clk_ff;
	logic force_gnd_ff;
	logic vref_oe_ff;

	// ----------------------------------------------------------------
	// decode and pin views
	// ----------------------------------------------------------------
	logic [7:0] idx;
	logic wr_go;
	logic [3:0] an_mask;
	logic [4:0] pa_view;
	logic cmp_route;
	logic chg_set;
	logic ext_set;
	logic [31:0] nxt_rdata;
	logic [4:0] nxt_pa_out;
	logic [4:0] nxt_pa_oe;
	logic pa4_val;

	assign idx = avs_address[9:2];
	assign wr_go = (bus_ff == DIO_BUS_ACK) && avs_write && avs_byteenable[0];

	always_comb begin
		case (cmp_ctrl_ff[2:0])
			`DIO_CM_OFF: an_mask = 4'h0;
			`DIO_CM_OUTPUTS: an_mask = `DIO_AN_MASK_OUT;
			default: an_mask = `DIO_AN_MASK_ALL;
		endcase
	end

	assign pa_view = pa_in & ~{1'b0, an_mask};
	assign cmp_route = (cmp_ctrl_ff[2:0] == `DIO_CM_OUTPUTS) && !pa_dir_ff[3] && !pa_dir_ff[4];

	// ----------------------------------------------------------------
	// bus slave: one wait cycle, answer at the second edge
	// ----------------------------------------------------------------
	always_comb begin
		nxt_rdata = 32'h0000_0000;
		case (idx)
			`DIO_IDX_PORT_A_PINS: nxt_rdata[4:0] = pa_view;
			`DIO_IDX_PORT_B_PINS: nxt_rdata[7:0] = pb_in;
			`DIO_IDX_PORT_A_DIR: nxt_rdata[7:0] = {3'h0, pa_dir_ff};
			`DIO_IDX_PORT_B_DIR: nxt_rdata[7:0] = pb_dir_ff;
			`DIO_IDX_OPTIONS: nxt_rdata[7:0] = opt_ff;
			`DIO_IDX_CMP_CTRL: nxt_rdata[7:0] = cmp_ctrl_ff;
			`DIO_IDX_REF_CTRL: nxt_rdata[7:0] = ref_ctrl_ff;
			`DIO_IDX_RMW_MASK: nxt_rdata[7:0] = rmw_mask_ff;
			`DIO_IDX_FLAGS: nxt_rdata[7:0] = {3'h0, ext_en_ff, 2'h0, ext_flag_ff, chg_flag_ff};
			default: nxt_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bus_ff <= DIO_BUS_IDLE;
			waitreq_ff <= 1'b1;
			rdata_ff <= 32'h0000_0000;
		end else begin
			case (bus_ff)
				DIO_BUS_IDLE: begin
					if (avs_read || avs_write) begin
						bus_ff <= DIO_BUS_ACK;
						waitreq_ff <= 1'b0;
						rdata_ff <= avs_read ? nxt_rdata : 32'h0000_0000;
					end
				end
				DIO_BUS_ACK: begin
					bus_ff <= DIO_BUS_IDLE;
					waitreq_ff <= 1'b1;
				end
				default: begin
					bus_ff <= DIO_BUS_IDLE;
					waitreq_ff <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// port latches and direction registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pa_latch_ff <= 5'h00;
			pb_latch_ff <= 8'h00;
		end else if (wr_go && idx == `DIO_IDX_PORT_A_PINS) begin
			pa_latch_ff <= (pa_view & ~rmw_mask_ff[4:0]) | (avs_writedata[4:0] & rmw_mask_ff[4:0]);
		end else if (wr_go && idx == `DIO_IDX_PORT_B_PINS) begin
			pb_latch_ff <= (pb_in & ~rmw_mask_ff) | (avs_writedata[7:0] & rmw_mask_ff);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pa_dir_ff <= `DIO_RST_PORT_A_DIR;
			pb_dir_ff <= `DIO_RST_PORT_B_DIR;
			opt_ff <= `DIO_RST_OPTIONS;
			cmp_ctrl_ff <= `DIO_RST_CMP_CTRL;
			ref_ctrl_ff <= `DIO_RST_REF_CTRL;
			rmw_mask_ff <= `DIO_RST_RMW_MASK;
		end else if (wr_go) begin
			case (idx)
				`DIO_IDX_PORT_A_DIR: pa_dir_ff <= avs_writedata[4:0];
				`DIO_IDX_PORT_B_DIR: pb_dir_ff <= avs_writedata[7:0];
				`DIO_IDX_OPTIONS: opt_ff <= avs_writedata[7:0];
				`DIO_IDX_CMP_CTRL: cmp_ctrl_ff <= avs_writedata[7:0];
				`DIO_IDX_REF_CTRL: ref_ctrl_ff <= avs_writedata[7:0];
				`DIO_IDX_RMW_MASK: rmw_mask_ff <= avs_writedata[7:0];
				default: rmw_mask_ff <= rmw_mask_ff;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// event flags: a set wins over a write in the same edge
	// ----------------------------------------------------------------
	dio_chg_det u_chg (
		.clk(clk),
		.arst_n(arst_n),
		.pins(pb_in[7:4]),
		.in_mask(pb_dir_ff[7:4]),
		.change(chg_set)
	);

	// no edge is seen until one real sample has been taken after reset
	assign ext_set = pb0_arm_ff && (pb_in[0] != pb0_prev_ff)
		&& (pb_in[0] == opt_ff[`DIO_OPT_EDGE_RISE]);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			chg_flag_ff <= 1'b0;
			ext_flag_ff <= 1'b0;
			ext_en_ff <= 1'b0;
			pb0_prev_ff <= 1'b0;
			pb0_arm_ff <= 1'b0;
		end else begin
			pb0_prev_ff <= pb_in[0];
			pb0_arm_ff <= 1'b1;
			if (wr_go && idx == `DIO_IDX_FLAGS) begin
				chg_flag_ff <= avs_writedata[`DIO_FLG_CHANGE] | chg_set;
				ext_flag_ff <= avs_writedata[`DIO_FLG_EXT] | ext_set;
				ext_en_ff <= avs_writedata[`DIO_FLG_EXT_EN];
			end else begin
				chg_flag_ff <= chg_flag_ff | chg_set;
				ext_flag_ff <= ext_flag_ff | ext_set;
			end
		end
	end

	// ----------------------------------------------------------------
	// pin drivers
	// ----------------------------------------------------------------
	assign pa4_val = cmp_route ? cmp_result[1] : pa_latch_ff[4];

	always_comb begin
		nxt_pa_out = pa_latch_ff;
		nxt_pa_oe = ~pa_dir_ff;
		if (cmp_route) begin
			nxt_pa_out[3] = cmp_result[0];
		end
		nxt_pa_out[4] = 1'b0;
		nxt_pa_oe[4] = !pa_dir_ff[4] && !pa4_val;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pa_out_ff <= 5'h00;
			pa_oe_ff <= 5'h00;
			pb_out_ff <= 8'h00;
			pb_oe_ff <= 8'h00;
			pb_pu_ff <= 8'h00;
			pb_st_ff <= 8'h00;
			tmr_clk_ff <= 1'b0;
			force_gnd_ff <= 1'b1;
			vref_oe_ff <= 1'b0;
		end else begin
			pa_out_ff <= nxt_pa_out;
			pa_oe_ff <= nxt_pa_oe;
			pb_out_ff <= pb_latch_ff;
			pb_oe_ff <= ~pb_dir_ff;
			pb_pu_ff <= {8{~opt_ff[`DIO_OPT_PULLUP_DIS_N]}} & pb_dir_ff;
			pb_st_ff <= {prog_mode, prog_mode, 5'h00, ext_en_ff};
			tmr_clk_ff <= pa_in[4];
			force_gnd_ff <= cmp_ctrl_ff[2:0] == `DIO_CM_RESET;
			vref_oe_ff <= ref_ctrl_ff[`DIO_REF_EN] && ref_ctrl_ff[`DIO_REF_OE];
		end
	end

	assign avs_readdata = rdata_ff;
	assign avs_waitrequest = waitreq_ff;
	assign pa_out = pa_out_ff;
	assign pa_oe = pa_oe_ff;
	assign pb_out = pb_out_ff;
	assign pb_oe = pb_oe_ff;
	assign pb_pullup_en = pb_pu_ff;
	assign pb_schmitt_en = pb_st_ff;
	assign timer_ext_clock_in = tmr_clk_ff;
	assign cmp_mode = cmp_ctrl_ff[2:0];
	assign cmp_force_gnd = force_gnd_ff;
	assign vref_out_en = vref_oe_ff;
	assign port_change_flag = chg_flag_ff;
	assign ext_int_flag = ext_flag_ff;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking dio_cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	chk_dir_float: assert property (pa_dir_ff[2:0] == 3'h7 |=> pa_oe[2:0] == 3'h0)
		else $error("port a driver on while direction is input");
	chk_ra4_drain: assert property (pa_out[4] == 1'b0)
		else $error("port a bit four drove high");
	chk_ra4_release: assert property (pa_dir_ff[4] |=> !pa_oe[4])
		else $error("port a bit four pulled low while input");
	chk_pin_read: assert property (
		bus_ff == DIO_BUS_IDLE && avs_read && idx == `DIO_IDX_PORT_B_PINS
		|=> !avs_waitrequest && avs_readdata[7:0] == $past(pb_in))
		else $error("port b read did not return pin levels");
	chk_an_zero: assert property (
		bus_ff == DIO_BUS_IDLE && avs_read && idx == `DIO_IDX_PORT_A_PINS
		&& cmp_ctrl_ff[2:0] == `DIO_CM_RESET |=> avs_readdata[3:0] == 4'h0)
		else $error("comparator input pin did not read zero");
	chk_rmw_store: assert property (
		wr_go && idx == `DIO_IDX_PORT_B_PINS
		|=> pb_latch_ff == (($past(pb_in) & ~$past(rmw_mask_ff)) |
		($past(avs_writedata[7:0]) & $past(rmw_mask_ff))))
		else $error("port b latch not loaded by read-modify-write");
	chk_tmr_route: assert property (pa_in[4] |=> timer_ext_clock_in)
		else $error("timer clock input not following port a bit four");
	chk_chg_hold: assert property (
		port_change_flag && !(wr_go && idx == `DIO_IDX_FLAGS) |=> port_change_flag)
		else $error("change flag dropped without software clear");
	chk_ext_edge: assert property (
		pb0_arm_ff && $rose(pb_in[0]) && opt_ff[`DIO_OPT_EDGE_RISE] |=> ext_int_flag)
		else $error("rising edge on interrupt pin not flagged");
	chk_gnd_reset: assert property (cmp_ctrl_ff[2:0] == `DIO_CM_RESET |=> cmp_force_gnd)
		else $error("comparator inputs not grounded in reset mode");
	chk_chg_set: assert property (pb_dir_ff[5] && $changed(pb_in[5]) |=> ##1 port_change_flag)
		else $error("change on port b bit five not flagged");
	chk_pullup_out: assert property (!pb_dir_ff[1] |=> !pb_pullup_en[1])
		else $error("pull-up left on an output pin");
	chk_pullup_on: assert property (pb_dir_ff[3] && !opt_ff[7] |=> pb_pullup_en[3])
		else $error("pull-up not enabled");
	chk_cmp_drive: assert property (cmp_route && cmp_result[0] |=> pa_out[3] && pa_oe[3])
		else $error("comparator output not on port a bit three");
	chk_prog_st: assert property (prog_mode |=> pb_schmitt_en[7:6] == 2'h3)
		else $error("programming pins not schmitt");
	chk_ext_st: assert property (ext_en_ff |=> pb_schmitt_en[0])
		else $error("interrupt pin not schmitt");
	chk_dir_a_read: assert property (
		bus_ff == DIO_BUS_IDLE && avs_read && idx == `DIO_IDX_PORT_A_DIR
		|=> avs_readdata[7:5] == 3'h0)
		else $error("port a direction upper bits not zero");

	cov_write_a: cover property (wr_go && idx == `DIO_IDX_PORT_A_PINS);
	cov_cmp_out: cover property (cmp_route ##1 pa_oe[3]);
	cov_chg_flag: cover property (!port_change_flag ##1 port_change_flag);
	cov_ext_flag: cover property (!ext_int_flag ##1 ext_int_flag);
	cov_prog_mode: cover property (prog_mode ##1 pb_schmitt_en[7]);
endmodule

// [test/dio_pin_model.sv]
// board side of the dual i/o port pins
`timescale 1ns/1ps
module dio_pin_model
	import dio_pkg::*;
(
	// driven by the port
	input wire logic [4:0] pa_out,
	input wire logic [4:0] pa_oe,
	input wire logic [7:0] pb_out,
	input wire logic [7:0] pb_oe,
	input wire logic [7:0] pb_pullup_en,
	// board drivers
	input wire logic [4:0] pa_ext,
	input wire logic [7:0] pb_ext,
	input wire logic [7:0] pb_ext_en,
	// resolved pin levels
	output logic [4:0] pa_in,
	output logic [7:0] pb_in
);
	// ----------------------------------------------------------------
	// pin resolution
	// ----------------------------------------------------------------
	// bit four can only pull low, whatever its output value says
	assign pa_in = (pa_oe & pa_out & 5'h0F) | (~pa_oe & pa_ext);
	// undriven, unpulled pins float to the inverse of the latch
	assign pb_in = (pb_oe & pb_out) | (~pb_oe & pb_ext_en & pb_ext)
		| (~pb_oe & ~pb_ext_en & (pb_pullup_en | ~pb_out));
endmodule

// [test/dio_top_tb_top.sv]
// self-checking bench for the dual i/o port
`timescale 1ns/1ps
`include "dio_defs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_fail++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module dio_top_tb_top
	import dio_pkg::*;
;
	logic clk, arst_n, avs_read, avs_write, avs_waitrequest, prog_mode;
	logic timer_ext_clock_in, cmp_force_gnd, vref_out_en, port_change_flag, ext_int_flag;
	logic [9:0] avs_address;
	logic [3:0] avs_byteenable;
	logic [31:0] avs_writedata, avs_readdata;
	logic [4:0] pa_in, pa_out, pa_oe, pa_ext;
	logic [7:0] pb_in, pb_out, pb_oe, pb_pullup_en, pb_schmitt_en, pb_ext, pb_ext_en;
	logic [1:0] cmp_result;
	logic [2:0] cmp_mode;
	int n_fail = 0;
	int total_checks = 0;
	dio_byte_t rd;

	dio_top dio_top_inst(.clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_byteenable,
		.avs_writedata, .avs_readdata, .avs_waitrequest, .pa_in, .pa_out, .pa_oe, .pb_in,
		.pb_out, .pb_oe, .pb_pullup_en, .pb_schmitt_en, .cmp_result, .prog_mode,
		.timer_ext_clock_in, .cmp_mode, .cmp_force_gnd, .vref_out_en, .port_change_flag,
		.ext_int_flag);
	dio_pin_model dio_pin_model_inst(.pa_out, .pa_oe, .pb_out, .pb_oe, .pb_pullup_en,
		.pa_ext, .pb_ext, .pb_ext_en, .pa_in, .pb_in);

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic finish_test;
		$display("mismatches %0d comparisons %0d", n_fail, total_checks);
		if (n_fail == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// request held until the rising edge that sees waitrequest low; data taken there
	task automatic bus(input logic wr, input logic [7:0] idx, input dio_byte_t d);
		int n;
		@(posedge clk);
		avs_address <= {idx, 2'b00};
		avs_writedata <= {24'h000000, d};
		avs_write <= wr;
		avs_read <= ~wr;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 20);
		if (avs_waitrequest !== 1'b0) begin
			n_fail++;
			finish_test();
		end
		rd = avs_readdata[7:0];
		avs_write <= 1'b0;
		avs_read <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] idx, input dio_byte_t d);
		bus(1'b1, idx, d);
	endtask

	task automatic rdchk(input logic [7:0] idx, input dio_byte_t e);
		bus(1'b0, idx, 8'h00);
		`CHK(rd, e)
	endtask

	task automatic settle;
		repeat (3) @(negedge clk);
	endtask

	task automatic pins(input logic [4:0] a, input logic [7:0] b);
		@(posedge clk);
		pa_ext <= a;
		pb_ext <= b;
		settle();
	endtask

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		settle();
		`CHK(cmp_force_gnd, 1'b1)
		`CHK(pa_oe, 5'h00)
		`CHK(port_change_flag, 1'b0)
		`CHK(ext_int_flag, 1'b0)
		rdchk(`DIO_IDX_PORT_A_DIR, 8'h1F);
		rdchk(`DIO_IDX_PORT_B_DIR, 8'hFF);
		rdchk(`DIO_IDX_OPTIONS, 8'hFF);
		rdchk(`DIO_IDX_CMP_CTRL, 8'h00);
		rdchk(`DIO_IDX_PORT_A_PINS, 8'h00);
		wr(8'h40, 8'h5A);
		rdchk(8'h40, 8'h00);
		@(posedge clk);
		avs_byteenable <= 4'hE;
		wr(`DIO_IDX_OPTIONS, 8'h00);
		avs_byteenable <= 4'hF;
		rdchk(`DIO_IDX_OPTIONS, 8'hFF);
	endtask

	task automatic t_port_a;
		wr(`DIO_IDX_PORT_A_PINS, 8'h00);
		wr(`DIO_IDX_CMP_CTRL, 8'h07);
		wr(`DIO_IDX_PORT_A_DIR, 8'hFF);
		rdchk(`DIO_IDX_PORT_A_DIR, 8'h1F);
		pins(5'h0A, 8'h00);
		rdchk(`DIO_IDX_PORT_A_PINS, 8'h0A);
		wr(`DIO_IDX_RMW_MASK, 8'h01);
		wr(`DIO_IDX_PORT_A_PINS, 8'h1F);
		wr(`DIO_IDX_RMW_MASK, 8'hFF);
		wr(`DIO_IDX_PORT_A_DIR, 8'h00);
		settle();
		`CHK(pa_out, 5'h0B)
		`CHK(pa_oe, 5'h1F)
		wr(`DIO_IDX_PORT_A_PINS, 8'h16);
		settle();
		`CHK(pa_out, 5'h06)
		`CHK(pa_oe, 5'h0F)
		rdchk(`DIO_IDX_PORT_A_PINS, 8'h06);
		pins(5'h10, 8'h00);
		rdchk(`DIO_IDX_PORT_A_PINS, 8'h16);
		`CHK(timer_ext_clock_in, 1'b1)
		pins(5'h00, 8'h00);
		`CHK(timer_ext_clock_in, 1'b0)
	endtask

	task automatic t_cmp;
		wr(`DIO_IDX_PORT_A_DIR, 8'h1F);
		pins(5'h1F, 8'h00);
		for (int m = 0; m < 8; m++) begin
			wr(`DIO_IDX_CMP_CTRL, 8'(m));
			rdchk(`DIO_IDX_PORT_A_PINS, (m == 7) ? 8'h1F : (m == 6) ? 8'h18 : 8'h10);
			`CHK(cmp_mode, 3'(m))
			`CHK(cmp_force_gnd, (m == 0))
		end
		wr(`DIO_IDX_CMP_CTRL, 8'h06);
		wr(`DIO_IDX_PORT_A_DIR, 8'h07);
		cmp_result <= 2'b01;
		settle();
		`CHK(pa_oe[4:3], 2'b11)
		`CHK(pa_out[3], 1'b1)
		@(posedge clk);
		cmp_result <= 2'b10;
		settle();
		`CHK(pa_out[3], 1'b0)
		`CHK(pa_oe[4], 1'b0)
		@(posedge clk);
		cmp_result <= 2'b01;
		wr(`DIO_IDX_PORT_A_DIR, 8'h17);
		settle();
		`CHK(pa_out[3], 1'b0)
		wr(`DIO_IDX_REF_CTRL, 8'hC0);
		settle();
		`CHK(vref_out_en, 1'b1)
	endtask

	task automatic t_port_b;
		wr(`DIO_IDX_OPTIONS, 8'h7F);
		settle();
		`CHK(pb_pullup_en, 8'hFF)
		wr(`DIO_IDX_PORT_B_DIR, 8'h0F);
		wr(`DIO_IDX_PORT_B_PINS, 8'hA5);
		settle();
		`CHK(pb_oe, 8'hF0)
		`CHK(pb_out, 8'hA5)
		`CHK(pb_pullup_en, 8'h0F)
		rdchk(`DIO_IDX_PORT_B_PINS, 8'hAF);
		wr(`DIO_IDX_OPTIONS, 8'hFF);
		settle();
		`CHK(pb_pullup_en, 8'h00)
		wr(`DIO_IDX_PORT_B_DIR, 8'hFF);
		pb_ext_en <= 8'hFF;
		pins(5'h00, 8'h00);
		wr(`DIO_IDX_FLAGS, 8'h00);
		pins(5'h00, 8'h04);
		`CHK(port_change_flag, 1'b0)
		pins(5'h00, 8'h44);
		`CHK(port_change_flag, 1'b1)
		settle();
		`CHK(port_change_flag, 1'b1)
		wr(`DIO_IDX_FLAGS, 8'h10);
		settle();
		`CHK(port_change_flag, 1'b0)
		`CHK(ext_int_flag, 1'b0)
		`CHK(pb_schmitt_en[0], 1'b1)
		pins(5'h00, 8'h45);
		`CHK(ext_int_flag, 1'b1)
		rdchk(`DIO_IDX_FLAGS, 8'h12);
		// falling edge select, interrupt enable off
		wr(`DIO_IDX_OPTIONS, 8'hBF);
		wr(`DIO_IDX_FLAGS, 8'h00);
		pins(5'h00, 8'h44);
		`CHK(ext_int_flag, 1'b1)
		wr(`DIO_IDX_FLAGS, 8'h10);
		pins(5'h00, 8'h45);
		`CHK(ext_int_flag, 1'b0)
		@(posedge clk);
		prog_mode <= 1'b1;
		settle();
		`CHK(pb_schmitt_en[7:6], 2'b11)
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		arst_n = 1'b0;
		avs_address = 10'h000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_byteenable = 4'hF;
		avs_writedata = 32'h00000000;
		pa_ext = 5'h0F;
		pb_ext = 8'h00;
		pb_ext_en = 8'h00;
		cmp_result = 2'b00;
		prog_mode = 1'b0;
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_port_a();
		t_cmp();
		t_port_b();
		finish_test();
	end
endmodule
